// *** design/hdlc_status_pkg.sv ***
package hdlc_status_pkg;

    // 5-bit register offsets on the 8-bit parallel port
    localparam logic [4:0] STATUS_ADDR = 5'h03;
    localparam logic [4:0] MASK_ADDR = 5'h04;
    localparam logic [4:0] FLAGS_ADDR = 5'h04;
    localparam logic [4:0] RX_DATA_ADDR = 5'h05;
    localparam logic [4:0] ADDR1_ADDR = 5'h06;
    localparam logic [4:0] ADDR2_ADDR = 5'h07;

    // Reset values and the unmapped read value
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] ADDR1_RESET = 8'h00;
    localparam logic [7:0] ADDR2_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Event bit positions in mask and flag registers
    localparam int EV_COLLISION = 7;
    localparam int EV_RX_END = 6;
    localparam int EV_TX_END = 5;
    localparam int EV_ABORT = 4;
    localparam int EV_TX_LOW = 3;
    localparam int EV_TX_UNDERRUN = 2;
    localparam int EV_RX_FULL = 1;
    localparam int EV_RX_OVERFLOW = 0;

    // Address register fields
    localparam int ADDR_COMPARE_EN_BIT = 0;
    localparam logic [6:0] BROADCAST_ADDR = 7'h7F;

    // Head byte kind codes
    localparam logic [1:0] KIND_PACKET = 2'h0;
    localparam logic [1:0] KIND_FIRST = 2'h1;
    localparam logic [1:0] KIND_LAST_GOOD = 2'h2;
    localparam logic [1:0] KIND_LAST_BAD = 2'h3;

    // Transmit fill codes
    localparam logic [1:0] TXQ_FULL = 2'h0;
    localparam logic [1:0] TXQ_FIVE = 2'h1;
    localparam logic [1:0] TXQ_EMPTY = 2'h2;
    localparam logic [1:0] TXQ_FOUR = 2'h3;

    // Receive fill codes
    localparam logic [1:0] RXQ_EMPTY = 2'h0;
    localparam logic [1:0] RXQ_PART = 2'h1;
    localparam logic [1:0] RXQ_HIGH = 2'h2;
    localparam logic [1:0] RXQ_FULL = 2'h3;

    // Queue levels
    localparam logic [4:0] FIFO_DEPTH = 5'h13;
    localparam logic [4:0] FIFO_LAST = 5'h12;
    localparam logic [4:0] RX_FULL_LEVEL = 5'h0F;
    localparam logic [4:0] TX_LOW_LEVEL = 5'h04;
    localparam logic [4:0] TX_FIVE_LEVEL = 5'h05;

    // Address filter states
    typedef enum logic [3:0] {
        FILT_WAIT = 4'b0001,
        FILT_SECOND = 4'b0010,
        FILT_BODY = 4'b0100,
        FILT_DROP = 4'b1000
    } filter_state_t;

endpackage

// *** design/event_latch.sv ***
`timescale 1ns/1ps

// One sticky event bit; a set in the clearing cycle survives
module event_latch #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_set,
    input wire logic i_clear,
    // State
    output logic o_flag
);

    // Set has priority over clear so no event is lost
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flag <= RESET_VAL;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end

endmodule

// *** design/hdlc_status_irq_addr_filter.sv ***
`timescale 1ns/1ps

module hdlc_status_irq_addr_filter
    import hdlc_status_pkg::*;
(
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // Host parallel port
    input wire logic [4:0] I_HOST_ADDR,
    input wire logic I_HOST_RD,
    input wire logic I_HOST_WR,
    input wire logic [7:0] I_HOST_WDATA,
    output logic [7:0] O_HOST_RDATA,
    output logic O_HOST_RVALID,
    // Mode and control from the controller
    input wire logic I_TE_MODE,
    input wire logic I_TX_ENABLE,
    input wire logic I_ADDRESS_FILTER_ENABLE,
    // Receiver byte stream and line events
    input wire logic I_RX_BYTE_VALID,
    input wire logic [7:0] I_RX_BYTE,
    input wire logic I_RX_FIRST,
    input wire logic I_RX_LAST,
    input wire logic I_RX_FCS_GOOD,
    input wire logic I_RX_FLAG_SEEN,
    input wire logic I_RX_CLOSE_SEEN,
    input wire logic I_RX_ABORT_SEEN,
    input wire logic I_RX_INVALID,
    input wire logic I_RX_IDLE,
    // Echo check
    input wire logic I_ECHO_VALID,
    input wire logic I_ECHO_BIT,
    input wire logic I_TX_D_BIT,
    // Transmit queue view
    input wire logic [4:0] I_TX_LEVEL,
    input wire logic I_TX_PUSH,
    input wire logic I_TX_POP,
    input wire logic I_TX_POP_END_TAG,
    input wire logic I_TX_FRAME_START,
    input wire logic I_TX_CLOSE_SENT,
    // Outputs to controller and host
    output logic O_IRQ,
    output logic O_RX_ENABLED,
    output logic O_TX_ABORT_REQ,
    output logic O_D_PRIORITY_HIGH
);

    logic [7:0] mask_reg;
    logic [7:0] addr1_reg;
    logic [7:0] addr2_reg;
    logic [7:0] flags;
    logic [7:0] events;
    logic [7:0] eff_mask;
    logic flags_clear;
    logic summary;
    logic [9:0] rx_mem [0:18];
    logic [4:0] wr_ptr_reg;
    logic [4:0] rd_ptr_reg;
    logic [4:0] count_reg;
    logic rx_enabled_reg;
    logic push;
    logic pop;
    logic push_attempt;
    logic overflow_evt;
    logic tx_low_evt;
    logic underrun_evt;
    logic [1:0] rx_fill;
    logic [1:0] tx_fill;
    logic [1:0] head_kind;
    filter_state_t state_reg;
    filter_state_t state_next;
    logic [7:0] stage_data_reg;
    logic [1:0] stage_kind_reg;
    logic stage_valid_reg;
    logic stage_last_reg;
    logic take;
    logic [1:0] new_kind;
    logic match1;
    logic match2;
    logic stage_load;
    logic stage_drop;
    logic [7:0] rd_value;

    // Host write decode
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mask_reg <= MASK_RESET;
            addr1_reg <= ADDR1_RESET;
            addr2_reg <= ADDR2_RESET;
        end else if (I_HOST_WR) begin
            unique case (I_HOST_ADDR)
                MASK_ADDR: mask_reg <= I_HOST_WDATA;
                ADDR1_ADDR: addr1_reg <= I_HOST_WDATA;
                ADDR2_ADDR: addr2_reg <= I_HOST_WDATA;
                default: ;
            endcase
        end
    end

    // Event sources
    always_comb begin
        tx_low_evt = I_TX_POP && !I_TX_PUSH
            && I_TX_LEVEL == TX_FIVE_LEVEL;
        underrun_evt = I_TX_POP && !I_TX_PUSH && !I_TX_POP_END_TAG
            && I_TX_LEVEL == 5'h01;
        events = 8'h00;
        events[EV_COLLISION] = I_TE_MODE && I_TX_ENABLE && I_ECHO_VALID
            && (I_ECHO_BIT != I_TX_D_BIT);
        events[EV_RX_END] = I_RX_CLOSE_SEEN || I_RX_ABORT_SEEN
            || I_RX_INVALID;
        events[EV_TX_END] = I_TX_CLOSE_SENT;
        events[EV_ABORT] = I_RX_ABORT_SEEN;
        events[EV_TX_LOW] = tx_low_evt;
        events[EV_TX_UNDERRUN] = underrun_evt;
        events[EV_RX_FULL] = count_reg >= RX_FULL_LEVEL;
        events[EV_RX_OVERFLOW] = overflow_evt;
    end

    // Reading the flag register clears it after the value is captured
    assign flags_clear = I_HOST_RD && I_HOST_ADDR == FLAGS_ADDR;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            event_latch #(.RESET_VAL(1'b0)) u_latch (
                .i_clk(I_SYS_CLK),
                .i_rst_n(I_RST_N),
                .i_set(events[gi]),
                .i_clear(flags_clear),
                .o_flag(flags[gi])
            );
        end
    endgenerate

    // Collision enable is ignored outside TE mode
    always_comb begin
        eff_mask = mask_reg;
        eff_mask[EV_COLLISION] = mask_reg[EV_COLLISION] && I_TE_MODE;
        summary = |(flags & eff_mask);
    end

    // Interrupt line lags the summary bit by one cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= summary;
        end
    end

    // Abort request and D-channel priority toward the transmitter
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_TX_ABORT_REQ <= 1'b0;
            O_D_PRIORITY_HIGH <= 1'b0;
        end else begin
            O_TX_ABORT_REQ <= underrun_evt;
            if (I_TX_CLOSE_SENT) begin
                O_D_PRIORITY_HIGH <= 1'b0;
            end else if (I_TX_FRAME_START) begin
                O_D_PRIORITY_HIGH <= 1'b1;
            end
        end
    end

    // Address comparison; both compares are skipped when filtering is off
    always_comb begin
        take = I_RX_BYTE_VALID && rx_enabled_reg;
        if (I_RX_FIRST) begin
            new_kind = KIND_FIRST;
        end else if (I_RX_LAST) begin
            new_kind = I_RX_FCS_GOOD ? KIND_LAST_GOOD : KIND_LAST_BAD;
        end else begin
            new_kind = KIND_PACKET;
        end
        match1 = !I_ADDRESS_FILTER_ENABLE
            || !addr1_reg[ADDR_COMPARE_EN_BIT]
            || I_RX_BYTE[7:2] == addr1_reg[7:2];
        match2 = !I_ADDRESS_FILTER_ENABLE
            || !addr2_reg[ADDR_COMPARE_EN_BIT]
            || I_RX_BYTE[7:1] == addr2_reg[7:1]
            || I_RX_BYTE[7:1] == BROADCAST_ADDR;
    end

    // Filter sequencing: one byte is staged until its packet is judged
    always_comb begin
        state_next = state_reg;
        stage_load = 1'b0;
        stage_drop = 1'b0;
        push = 1'b0;
        if (I_RX_ABORT_SEEN || overflow_evt) begin
            state_next = FILT_WAIT;
            stage_drop = 1'b1;
        end else if (take && I_RX_FIRST) begin
            push = stage_valid_reg && state_reg == FILT_BODY;
            if (match1) begin
                stage_load = 1'b1;
                state_next = I_RX_LAST ? FILT_WAIT : FILT_SECOND;
            end else begin
                stage_drop = 1'b1;
                state_next = FILT_DROP;
            end
        end else if (take) begin
            unique case (state_reg)
                FILT_SECOND: begin
                    if (match2) begin
                        push = stage_valid_reg;
                        stage_load = 1'b1;
                        state_next = I_RX_LAST ? FILT_WAIT : FILT_BODY;
                    end else begin
                        stage_drop = 1'b1;
                        state_next = FILT_DROP;
                    end
                end
                FILT_BODY: begin
                    push = stage_valid_reg;
                    stage_load = 1'b1;
                    if (I_RX_LAST) begin
                        state_next = FILT_WAIT;
                    end
                end
                FILT_WAIT, FILT_DROP: ;
            endcase
        end else if (stage_valid_reg && stage_last_reg) begin
            push = 1'b1;
            stage_drop = 1'b1;
        end
    end

    // Filter state and staged byte
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= FILT_WAIT;
            stage_data_reg <= 8'h00;
            stage_kind_reg <= KIND_PACKET;
            stage_valid_reg <= 1'b0;
            stage_last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (stage_load) begin
                stage_data_reg <= I_RX_BYTE;
                stage_kind_reg <= new_kind;
                stage_valid_reg <= 1'b1;
                stage_last_reg <= I_RX_LAST;
            end else if (stage_drop) begin
                stage_valid_reg <= 1'b0;
                stage_last_reg <= 1'b0;
            end
        end
    end

    // Receive queue control
    assign pop = I_HOST_RD && I_HOST_ADDR == RX_DATA_ADDR
        && count_reg != 5'h00;
    assign push_attempt = push && rx_enabled_reg;
    assign overflow_evt = take && count_reg == FIFO_DEPTH && !pop;

    // Queue storage; a stored byte keeps its kind beside it
    always_ff @(posedge I_SYS_CLK) begin
        if (push_attempt && (count_reg != FIFO_DEPTH || pop)) begin
            rx_mem[wr_ptr_reg] <= {stage_kind_reg, stage_data_reg};
        end
    end

    // Queue pointers and count
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            count_reg <= 5'h00;
        end else begin
            if (push_attempt && (count_reg != FIFO_DEPTH || pop)) begin
                wr_ptr_reg <= wr_ptr_reg == FIFO_LAST ? 5'h00
                    : wr_ptr_reg + 5'h01;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg == FIFO_LAST ? 5'h00
                    : rd_ptr_reg + 5'h01;
            end
            if ((push_attempt && (count_reg != FIFO_DEPTH || pop)) && !pop)
            begin
                count_reg <= count_reg + 5'h01;
            end else if (pop && !push_attempt) begin
                count_reg <= count_reg - 5'h01;
            end
        end
    end

    // Receiver halts on overflow and resumes on the next flag
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_enabled_reg <= 1'b1;
        end else if (overflow_evt) begin
            rx_enabled_reg <= 1'b0;
        end else if (I_RX_FLAG_SEEN) begin
            rx_enabled_reg <= 1'b1;
        end
    end
    assign O_RX_ENABLED = rx_enabled_reg;

    // Fill and head status codes
    always_comb begin
        head_kind = count_reg == 5'h00 ? KIND_PACKET
            : rx_mem[rd_ptr_reg][9:8];
        if (count_reg == 5'h00) begin
            rx_fill = RXQ_EMPTY;
        end else if (count_reg == FIFO_DEPTH) begin
            rx_fill = RXQ_FULL;
        end else if (count_reg >= RX_FULL_LEVEL) begin
            rx_fill = RXQ_HIGH;
        end else begin
            rx_fill = RXQ_PART;
        end
        if (I_TX_LEVEL >= FIFO_DEPTH) begin
            tx_fill = TXQ_FULL;
        end else if (I_TX_LEVEL == 5'h00) begin
            tx_fill = TXQ_EMPTY;
        end else if (I_TX_LEVEL >= TX_FIVE_LEVEL) begin
            tx_fill = TXQ_FIVE;
        end else begin
            tx_fill = TXQ_FOUR;
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        unique case (I_HOST_ADDR)
            STATUS_ADDR: rd_value = {head_kind, rx_fill, tx_fill,
                I_RX_IDLE, summary};
            FLAGS_ADDR: rd_value = {flags[7] && I_TE_MODE, flags[6:0]};
            RX_DATA_ADDR: rd_value = count_reg == 5'h00 ? UNMAPPED_READ
                : rx_mem[rd_ptr_reg][7:0];
            ADDR1_ADDR: rd_value = addr1_reg;
            ADDR2_ADDR: rd_value = addr2_reg;
            default: rd_value = UNMAPPED_READ;
        endcase
    end

    // Read data is registered and valid for one cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_HOST_RDATA <= 8'h00;
            O_HOST_RVALID <= 1'b0;
        end else begin
            O_HOST_RVALID <= I_HOST_RD;
            if (I_HOST_RD) begin
                O_HOST_RDATA <= rd_value;
            end
        end
    end

    AST_TX_EMPTY_CODE: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) I_TX_LEVEL == 5'h00 |-> tx_fill == 2'h2)
        else $error("empty tx queue not coded 10");
    AST_READ_CLEARS: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) flags_clear && events == 8'h00
        |=> flags == 8'h00) else $error("flag read did not clear");
    AST_OVF_STOPS: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) overflow_evt |=> !O_RX_ENABLED
        && flags[0]) else $error("overflow did not stop receiver");
    AST_NT_COLL_ZERO: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) flags_clear && !I_TE_MODE
        |=> !O_HOST_RDATA[7]) else $error("collision read in NT");
    AST_IRQ_SUMMARY: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) ##1 O_IRQ
        == $past(|(flags & mask_reg & {I_TE_MODE, 7'h7F})))
        else $error("irq not OR of enabled flags");
    AST_RX_FULL: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) count_reg >= 5'h0F |=> flags[1])
        else $error("rx full flag missing");
    AST_UNDERRUN_ABORT: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) underrun_evt |=> O_TX_ABORT_REQ && flags[2])
        else $error("underrun without abort");
    AST_TX_LOW: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) I_TX_PUSH && !flags[EV_TX_LOW]
        |=> !flags[EV_TX_LOW]) else $error("tx low set while filling");
    AST_PRIO_DROP: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) I_TX_CLOSE_SENT
        |=> !O_D_PRIORITY_HIGH && flags[5]) else $error("priority kept");
    AST_DROP_NO_STORE: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) state_reg == FILT_DROP && !stage_valid_reg
        |-> !push) else $error("dropped packet stored");

endmodule

// *** test/host_port_model.sv ***
`timescale 1ns/1ps

// Host side of the 8-bit parallel port
module host_port_model (
    // Clock
    input wire logic i_clk,
    // Port to the device
    output logic [4:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    logic [7:0] rdat;

    // Quiet port until the first access
    initial begin
        {o_addr, o_rd, o_wr, o_wdata} = '0;
    end

    // One-cycle strobe, address and data held through the taking edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d; // Stale data must never be reused
    endtask

    // Valid must follow the strobe by one cycle; a late pulse reads unknown
    task automatic rd(input logic [4:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        rdat = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
    endtask
endmodule

// *** test/hdlc_status_irq_addr_filter_tb.sv ***
`timescale 1ns/1ps

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("FAIL %0t got %h exp %h", $time, (a), (e)); end end

module hdlc_status_irq_addr_filter_tb import hdlc_status_pkg::*;;
    logic clk = 1'b0;
    logic rst_n, te, txen, filt, idle, eb, db, push, pop, etag;
    logic rxv, rxf, rxl, fcs, hrv, irq, rxen, abreq, prio, hrd, hwr;
    logic [6:0] ev; // flag, close, abort, invalid, start, sent, echo
    logic [7:0] rxb, hrdata, hwd;
    logic [4:0] lvl, haddr;
    int err_total = 0;
    int cmp_count = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    hdlc_status_irq_addr_filter uut (.I_SYS_CLK(clk), .I_RST_N(rst_n),
        .I_HOST_ADDR(haddr), .I_HOST_RD(hrd), .I_HOST_WR(hwr),
        .I_HOST_WDATA(hwd), .O_HOST_RDATA(hrdata), .O_HOST_RVALID(hrv),
        .I_TE_MODE(te), .I_TX_ENABLE(txen), .I_ADDRESS_FILTER_ENABLE(filt),
        .I_RX_BYTE_VALID(rxv), .I_RX_BYTE(rxb), .I_RX_FIRST(rxf),
        .I_RX_LAST(rxl), .I_RX_FCS_GOOD(fcs), .I_RX_FLAG_SEEN(ev[0]),
        .I_RX_CLOSE_SEEN(ev[1]), .I_RX_ABORT_SEEN(ev[2]),
        .I_RX_INVALID(ev[3]), .I_RX_IDLE(idle), .I_ECHO_VALID(ev[6]),
        .I_ECHO_BIT(eb), .I_TX_D_BIT(db), .I_TX_LEVEL(lvl),
        .I_TX_PUSH(push), .I_TX_POP(pop), .I_TX_POP_END_TAG(etag),
        .I_TX_FRAME_START(ev[4]), .I_TX_CLOSE_SENT(ev[5]), .O_IRQ(irq),
        .O_RX_ENABLED(rxen), .O_TX_ABORT_REQ(abreq),
        .O_D_PRIORITY_HIGH(prio));

    host_port_model host (.i_clk(clk), .o_addr(haddr), .o_rd(hrd),
        .o_wr(hwr), .o_wdata(hwd), .i_rdata(hrdata), .i_rvalid(hrv));

    task automatic test_done;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        host.rd(a);
        `CHK(host.rdat, e)
    endtask

    task automatic popchk(input logic [1:0] k, input logic [7:0] d);
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[7:6], k)
        rchk(RX_DATA_ADDR, d);
    endtask

    task automatic pulse(input int n);
        @(posedge clk);
        ev[n] <= 1'b1;
        @(posedge clk);
        ev[n] <= 1'b0;
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // Mid-run reset exercises the asynchronous path as well
    task automatic reset_dut;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Two cycles between bytes, as the receiver demands
    task automatic rx(input logic [7:0] b, input logic f, l, g);
        @(posedge clk);
        rxv <= 1'b1;
        rxb <= b;
        rxf <= f;
        rxl <= l;
        fcs <= g;
        @(posedge clk);
        rxv <= 1'b0;
        rxb <= ~b;
        rxf <= 1'b0;
        rxl <= 1'b0;
    endtask

    task automatic tpop(input logic [4:0] l, input logic p, t);
        @(posedge clk);
        lvl <= l;
        push <= p;
        etag <= t;
        pop <= 1'b1;
        @(posedge clk);
        {pop, push, etag} <= '0;
    endtask

    task automatic t_reset;
        rchk(FLAGS_ADDR, 8'h00);
        rchk(ADDR1_ADDR, ADDR1_RESET);
        rchk(ADDR2_ADDR, ADDR2_RESET);
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[5:0], {RXQ_EMPTY, TXQ_EMPTY, 2'b00})
        `CHK({rxen, irq, prio, abreq}, 4'h8)
    endtask

    // Read-only, write-only and unmapped places
    task automatic t_regs;
        host.wr(ADDR1_ADDR, 8'hA9);
        host.wr(ADDR2_ADDR, 8'h25);
        host.wr(STATUS_ADDR, 8'hFF);
        host.wr(5'h1F, 8'hFF);
        host.wr(MASK_ADDR, 8'h40);
        rchk(ADDR1_ADDR, 8'hA9);
        rchk(ADDR2_ADDR, 8'h25);
        rchk(MASK_ADDR, 8'h00);
        rchk(5'h1F, UNMAPPED_READ);
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[3:0], {TXQ_EMPTY, 2'b00})
        host.wr(MASK_ADDR, MASK_RESET);
    endtask

    task automatic t_txfill;
        logic [4:0] lv [6] = '{5'h13, 5'h12, 5'h05, 5'h00, 5'h04, 5'h01};
        logic [1:0] cd [6] = '{TXQ_FULL, TXQ_FIVE, TXQ_FIVE, TXQ_EMPTY,
            TXQ_FOUR, TXQ_FOUR};
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            lvl <= lv[k];
            idle <= k[0];
            host.rd(STATUS_ADDR);
            `CHK(host.rdat[3:1], {cd[k], k[0]})
        end
    endtask

    // Low mark only counts while draining
    task automatic t_txlow;
        tpop(TX_FIVE_LEVEL, 1'b1, 1'b0);
        rchk(FLAGS_ADDR, 8'h00);
        tpop(TX_LOW_LEVEL, 1'b0, 1'b0);
        rchk(FLAGS_ADDR, 8'h00);
        tpop(TX_FIVE_LEVEL, 1'b0, 1'b0);
        rchk(FLAGS_ADDR, 8'h08);
        rchk(FLAGS_ADDR, 8'h00);
    endtask

    task automatic t_under;
        int n = 0;
        tpop(5'h01, 1'b0, 1'b1);
        rchk(FLAGS_ADDR, 8'h00);
        tpop(5'h01, 1'b0, 1'b0);
        repeat (4) begin
            #1;
            n += (abreq === 1'b1);
            @(posedge clk);
        end
        `CHK(n, 1)
        rchk(FLAGS_ADDR, 8'h04);
    endtask

    task automatic t_prio;
        pulse(4);
        settle();
        `CHK(prio, 1'b1)
        rchk(FLAGS_ADDR, 8'h00);
        pulse(5);
        settle();
        `CHK(prio, 1'b0)
        rchk(FLAGS_ADDR, 8'h20);
    endtask

    task automatic t_coll;
        host.wr(MASK_ADDR, 8'h80);
        te <= 1'b1;
        txen <= 1'b1;
        eb <= 1'b1;
        pulse(6);
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[0], 1'b1)
        `CHK(irq, 1'b1)
        rchk(FLAGS_ADDR, 8'h80);
        rchk(FLAGS_ADDR, 8'h00);
        db <= 1'b1;
        pulse(6);
        rchk(FLAGS_ADDR, 8'h00);
        db <= 1'b0;
        txen <= 1'b0;
        pulse(6);
        rchk(FLAGS_ADDR, 8'h00);
        te <= 1'b0;
        txen <= 1'b1;
        pulse(6);
        rchk(FLAGS_ADDR, 8'h00);
        te <= 1'b1;
        pulse(6);
        te <= 1'b0;
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[0], 1'b0)
        host.wr(MASK_ADDR, 8'h00);
    endtask

    task automatic t_rxev;
        int src [3] = '{1, 2, 3};
        logic [7:0] ex [3] = '{8'h40, 8'h50, 8'h40};
        for (int k = 0; k < 3; k++) begin
            pulse(src[k]);
            rchk(FLAGS_ADDR, ex[k]);
        end
    endtask

    task automatic t_irq;
        host.wr(MASK_ADDR, 8'h40);
        pulse(1);
        repeat (2) settle();
        `CHK(irq, 1'b1)
        host.wr(MASK_ADDR, 8'h3F);
        host.rd(STATUS_ADDR);
        `CHK({host.rdat[0], irq}, 2'b00)
        rchk(FLAGS_ADDR, 8'h40);
        host.wr(MASK_ADDR, 8'h00);
    endtask

    // Second compare is 7'h12 with enable; first is 6'h2A with enable
    task automatic t_filter;
        rx(8'h11, 1'b1, 1'b0, 1'b0);
        rx(8'h22, 1'b0, 1'b0, 1'b0);
        rx(8'h33, 1'b0, 1'b1, 1'b0);
        popchk(KIND_FIRST, 8'h11);
        popchk(KIND_PACKET, 8'h22);
        popchk(KIND_LAST_BAD, 8'h33);
        filt <= 1'b1;
        rx(8'h54, 1'b1, 1'b0, 1'b1);
        rx(8'hFE, 1'b0, 1'b1, 1'b1);
        rx(8'hA8, 1'b1, 1'b0, 1'b1);
        rx(8'h30, 1'b0, 1'b1, 1'b1);
        rx(8'hA8, 1'b1, 1'b0, 1'b1);
        rx(8'hFE, 1'b0, 1'b1, 1'b1);
        rx(8'hA9, 1'b1, 1'b0, 1'b1);
        rx(8'h24, 1'b0, 1'b1, 1'b1);
        host.wr(ADDR1_ADDR, 8'h00);
        rx(8'h54, 1'b1, 1'b0, 1'b1);
        rx(8'h24, 1'b0, 1'b1, 1'b1);
        popchk(KIND_FIRST, 8'hA8);
        popchk(KIND_LAST_GOOD, 8'hFE);
        popchk(KIND_FIRST, 8'hA9);
        popchk(KIND_LAST_GOOD, 8'h24);
        popchk(KIND_FIRST, 8'h54);
        popchk(KIND_LAST_GOOD, 8'h24);
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[5:4], RXQ_EMPTY)
        filt <= 1'b0;
    endtask

    task automatic t_full;
        rx(8'h00, 1'b1, 1'b0, 1'b1);
        for (int k = 1; k < 15; k++) rx(k[7:0], 1'b0, 1'b0, 1'b1);
        host.rd(FLAGS_ADDR);
        `CHK(host.rdat[1], 1'b0)
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[5:4], RXQ_PART)
        rx(8'h0F, 1'b0, 1'b0, 1'b1);
        host.rd(FLAGS_ADDR);
        `CHK(host.rdat[1], 1'b1)
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[5:4], RXQ_HIGH)
        for (int k = 16; k < 21; k++) rx(k[7:0], 1'b0, 1'b0, 1'b1);
        settle();
        `CHK(rxen, 1'b0)
        host.rd(FLAGS_ADDR);
        `CHK(host.rdat[1:0], 2'b11)
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[5:4], RXQ_FULL)
        pulse(0);
        settle();
        `CHK(rxen, 1'b1)
        reset_dut();
        rchk(FLAGS_ADDR, 8'h00);
        host.rd(STATUS_ADDR);
        `CHK(host.rdat[5:4], RXQ_EMPTY)
    endtask

    // Main sequence
    initial begin
        {rst_n, te, txen, filt, idle, eb, db, push, pop, etag} = '0;
        {rxv, rxf, rxl, fcs, ev, rxb, lvl} = '0;
        reset_dut();
        t_reset();
        t_regs();
        t_txfill();
        t_txlow();
        t_under();
        t_prio();
        t_coll();
        t_rxev();
        t_irq();
        t_filter();
        t_full();
        test_done();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        err_total++;
        test_done();
    end
endmodule
